// ---- rtl/fpch_top.sv ----
// Flash programming command handler: serial link, command engine, flash array
`timescale 1ns/1ps
module fpch_top #(
    parameter int ADDR_W = fpch_pkg::FPCH_ADDR_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic prog_serial_pin_primary_in,
    output logic prog_serial_pin_primary_out,
    output logic prog_serial_pin_primary_oe_out,
    input wire logic prog_serial_pin_alternate_in,
    output logic prog_serial_pin_alternate_out,
    output logic prog_serial_pin_alternate_oe_out,
    input wire logic pin_sel_alternate_in,
    input wire logic self_prog_in,
    output logic prog_mode_out,
    output logic port_hold_reset_out,
    output logic port_hold_halt_out,
    output logic busy_out
);
    import fpch_pkg::*;
    localparam int NW = 1 << ADDR_W;

    // Two-flop sync of both data pins and the selector
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end else begin
            sync1_r <= {pin_sel_alternate_in, prog_serial_pin_alternate_in,
                        prog_serial_pin_primary_in};
            sync2_r <= sync1_r;
        end
    end
    wire sel_alt = sync2_r[2];
    // Own answer echoes on the shared wire; ignore the pin while driving it
    wire tx_echo = prog_serial_pin_primary_oe_out || prog_serial_pin_alternate_oe_out;
    wire rx_line = (sel_alt ? sync2_r[1] : sync2_r[0]) || tx_echo;

    // Bit-period divisor shared by receiver and transmitter; each keeps its own counter
    logic [1:0] baud_sel_r;
    wire [15:0] bit_div = (baud_sel_r == 2'h0) ? FPCH_DIV_0 :
                          (baud_sel_r == 2'h1) ? FPCH_DIV_1 :
                          (baud_sel_r == 2'h2) ? FPCH_DIV_2 : FPCH_DIV_3;

    // Receiver
    fpch_rx_t rx_st_r;
    logic [15:0] rx_cnt_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_vld_r;
    wire rx_tick = (rx_cnt_r == 16'h0000);
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            rx_st_r <= FPCH_RX_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_vld_r <= 1'b0;
        end else begin
            rx_vld_r <= 1'b0;
            rx_cnt_r <= rx_tick ? bit_div - 16'h0001 : rx_cnt_r - 16'h0001;
            unique case (rx_st_r)
                FPCH_RX_IDLE: if (!rx_line) begin
                    rx_st_r <= FPCH_RX_START;
                    rx_cnt_r <= {1'b0, bit_div[15:1]};
                end
                FPCH_RX_START: if (rx_tick) begin
                    rx_st_r <= rx_line ? FPCH_RX_IDLE : FPCH_RX_DATA;
                    rx_bit_r <= 3'h0;
                end
                FPCH_RX_DATA: if (rx_tick) begin
                    rx_sh_r <= {rx_line, rx_sh_r[7:1]};
                    rx_bit_r <= rx_bit_r + 3'h1;
                    if (rx_bit_r == 3'h7) begin
                        rx_st_r <= FPCH_RX_STOP;
                    end
                end
                FPCH_RX_STOP: if (rx_tick) begin
                    rx_st_r <= FPCH_RX_IDLE;
                    rx_vld_r <= rx_line;
                end
            endcase
        end
    end

    // Receive FIFO; its read side stalls while the engine runs a command or sends a response
    logic [7:0] fifo_data;
    logic fifo_vld;
    logic fifo_rdy;
    logic fifo_wr_rdy;
    fpch_fifo #(.WIDTH(8), .DEPTH(FPCH_FIFO_DEPTH)) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .wr_data_in(rx_sh_r),
        .wr_valid_in(rx_vld_r),
        .wr_ready_out(fifo_wr_rdy),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_vld),
        .rd_ready_in(fifo_rdy)
    );

    // Transmitter
    logic [9:0] tx_sh_r;
    logic [3:0] tx_left_r;
    logic [15:0] tx_cnt_r;
    logic tx_start;
    logic [7:0] tx_byte;
    wire tx_busy = (tx_left_r != 4'h0);
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            tx_sh_r <= 10'h3FF;
            tx_left_r <= 4'h0;
            tx_cnt_r <= 16'h0000;
        end else if (tx_start) begin
            tx_sh_r <= {1'b1, tx_byte, 1'b0};
            tx_left_r <= 4'hA;
            tx_cnt_r <= bit_div - 16'h0001;
        end else if (tx_busy) begin
            if (tx_cnt_r == 16'h0000) begin
                tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                tx_left_r <= tx_left_r - 4'h1;
                tx_cnt_r <= bit_div - 16'h0001;
            end else begin
                tx_cnt_r <= tx_cnt_r - 16'h0001;
            end
        end
    end

    // Flash array and engine
    logic [7:0] flash_r [NW];
    fpch_state_t st_r;
    logic [7:0] cmd_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] end_r;
    logic [1:0] argn_r;
    logic ok_r;
    logic [7:0] sum_r;
    logic [7:0] extra_r;
    logic [1:0] extra_n_r;
    logic mode_r;
    logic protect_r;
    logic tx_start_r;
    logic [7:0] tx_byte_r;
    assign tx_start = tx_start_r;
    assign tx_byte = tx_byte_r;

    wire pop = fifo_vld && (st_r == FPCH_IDLE || st_r == FPCH_GET_ARG ||
                            st_r == FPCH_GET_DATA);
    assign fifo_rdy = pop;
    wire is_known = (fifo_data == FPCH_CMD_SYNC) || (fifo_data == FPCH_CMD_VERIFY) ||
                    (fifo_data == FPCH_CMD_CHIP_ERASE) || (fifo_data == FPCH_CMD_BLOCK_ERASE) ||
                    (fifo_data == FPCH_CMD_BLANK) || (fifo_data == FPCH_CMD_WRITE) ||
                    (fifo_data == FPCH_CMD_SIGNATURE) || (fifo_data == FPCH_CMD_VERSION) ||
                    (fifo_data == FPCH_CMD_CHECKSUM) || (fifo_data == FPCH_CMD_SECURITY) ||
                    (fifo_data == FPCH_CMD_BAUD);
    // Range commands take start and end; block commands one block number
    wire needs_range = (fifo_data == FPCH_CMD_VERIFY) || (fifo_data == FPCH_CMD_WRITE) ||
                       (fifo_data == FPCH_CMD_CHECKSUM);
    wire needs_one = (fifo_data == FPCH_CMD_BLOCK_ERASE) || (fifo_data == FPCH_CMD_BLANK) ||
                     (fifo_data == FPCH_CMD_BAUD) || (fifo_data == FPCH_CMD_SECURITY);
    wire is_blk = (cmd_r == FPCH_CMD_BLOCK_ERASE) || (cmd_r == FPCH_CMD_BLANK);
    wire [ADDR_W-1:0] blk_base = ADDR_W'(fifo_data[FPCH_BLK_W-1:0]) << FPCH_BLK_SHIFT;
    wire [ADDR_W-1:0] blk_last = blk_base | ADDR_W'((1 << FPCH_BLK_SHIFT) - 1);
    wire last = (addr_r == end_r);
    wire [7:0] cur = flash_r[addr_r];

    always_ff @(posedge sys_clk_in) begin
        if (st_r == FPCH_GET_DATA && fifo_vld && cmd_r == FPCH_CMD_WRITE && !protect_r) begin
            flash_r[addr_r] <= fifo_data;
        end else if (st_r == FPCH_RUN && (cmd_r == FPCH_CMD_CHIP_ERASE ||
                     cmd_r == FPCH_CMD_BLOCK_ERASE) && !protect_r) begin
            flash_r[addr_r] <= FPCH_ERASED;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            st_r <= FPCH_IDLE;
            cmd_r <= 8'h00;
            addr_r <= '0;
            end_r <= '0;
            argn_r <= 2'h0;
            ok_r <= 1'b1;
            sum_r <= 8'h00;
            extra_r <= 8'h00;
            extra_n_r <= 2'h0;
            mode_r <= 1'b0;
            protect_r <= 1'b0;
            baud_sel_r <= 2'h0;
            tx_start_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end else begin
            tx_start_r <= 1'b0;
            unique case (st_r)
                FPCH_IDLE: if (fifo_vld) begin
                    mode_r <= 1'b1;
                    cmd_r <= fifo_data;
                    ok_r <= is_known;
                    sum_r <= 8'h00;
                    argn_r <= 2'h0;
                    if (!is_known) begin
                        st_r <= FPCH_SEND_RESP;
                    end else if (needs_range || needs_one) begin
                        st_r <= FPCH_GET_ARG;
                    end else if (fifo_data == FPCH_CMD_CHIP_ERASE) begin
                        addr_r <= '0;
                        end_r <= '1;
                        st_r <= FPCH_RUN;
                    end else begin
                        st_r <= FPCH_SEND_RESP;
                    end
                end
                FPCH_GET_ARG: if (fifo_vld) begin
                    if (cmd_r == FPCH_CMD_BAUD) begin
                        baud_sel_r <= fifo_data[1:0];
                        st_r <= FPCH_SEND_RESP;
                    end else if (cmd_r == FPCH_CMD_SECURITY) begin
                        protect_r <= fifo_data[0];
                        st_r <= FPCH_SEND_RESP;
                    end else if (is_blk) begin
                        addr_r <= blk_base;
                        end_r <= blk_last;
                        st_r <= FPCH_RUN;
                    end else if (argn_r == 2'h0) begin
                        addr_r <= ADDR_W'(fifo_data);
                        argn_r <= 2'h1;
                    end else begin
                        end_r <= ADDR_W'(fifo_data);
                        st_r <= (cmd_r == FPCH_CMD_CHECKSUM) ? FPCH_RUN : FPCH_GET_DATA;
                    end
                end
                FPCH_GET_DATA: if (fifo_vld) begin
                    if (cmd_r == FPCH_CMD_VERIFY && cur != fifo_data) begin
                        ok_r <= 1'b0;
                    end
                    if (cmd_r == FPCH_CMD_WRITE && protect_r) begin
                        ok_r <= 1'b0;
                    end
                    addr_r <= addr_r + ADDR_W'(1);
                    if (last) begin
                        st_r <= FPCH_SEND_RESP;
                    end
                end
                FPCH_RUN: begin
                    if (cmd_r == FPCH_CMD_BLANK && cur != FPCH_ERASED) begin
                        ok_r <= 1'b0;
                    end
                    if (cmd_r != FPCH_CMD_BLANK && cmd_r != FPCH_CMD_CHECKSUM && protect_r) begin
                        ok_r <= 1'b0;
                    end
                    sum_r <= sum_r + cur;
                    addr_r <= addr_r + ADDR_W'(1);
                    if (last) begin
                        st_r <= FPCH_SEND_RESP;
                    end
                end
                FPCH_SEND_RESP: if (!tx_busy && !tx_start_r) begin
                    tx_start_r <= 1'b1;
                    tx_byte_r <= ok_r ? FPCH_ACK : FPCH_NAK;
                    extra_n_r <= 2'h0;
                    st_r <= FPCH_WAIT_TX;
                    if (ok_r && cmd_r == FPCH_CMD_SIGNATURE) begin
                        extra_r <= FPCH_SIG_ID;
                        extra_n_r <= 2'h2;
                    end else if (ok_r && cmd_r == FPCH_CMD_VERSION) begin
                        extra_r <= FPCH_HW_VER;
                        extra_n_r <= 2'h2;
                    end else if (ok_r && cmd_r == FPCH_CMD_CHECKSUM) begin
                        extra_r <= sum_r;
                        extra_n_r <= 2'h1;
                    end
                end
                FPCH_SEND_EXTRA: if (!tx_busy && !tx_start_r) begin
                    tx_start_r <= 1'b1;
                    tx_byte_r <= extra_r;
                    extra_n_r <= extra_n_r - 2'h1;
                    // Second byte: address width or firmware version
                    extra_r <= (cmd_r == FPCH_CMD_SIGNATURE) ? 8'(ADDR_W) : FPCH_FW_VER;
                    st_r <= FPCH_WAIT_TX;
                end
                FPCH_WAIT_TX: if (!tx_busy && !tx_start_r) begin
                    st_r <= (extra_n_r != 2'h0) ? FPCH_SEND_EXTRA : FPCH_IDLE;
                end
                default: st_r <= FPCH_IDLE;
            endcase
        end
    end

    // Pin drivers: only the selected data pin is driven, half duplex
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            prog_serial_pin_primary_out <= 1'b1;
            prog_serial_pin_primary_oe_out <= 1'b0;
            prog_serial_pin_alternate_out <= 1'b1;
            prog_serial_pin_alternate_oe_out <= 1'b0;
            prog_mode_out <= 1'b0;
            port_hold_reset_out <= 1'b0;
            port_hold_halt_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            prog_serial_pin_primary_out <= tx_sh_r[0] || sel_alt;
            prog_serial_pin_primary_oe_out <= tx_busy && !sel_alt;
            prog_serial_pin_alternate_out <= tx_sh_r[0] || !sel_alt;
            prog_serial_pin_alternate_oe_out <= tx_busy && sel_alt;
            prog_mode_out <= mode_r;
            port_hold_reset_out <= mode_r;
            port_hold_halt_out <= self_prog_in && !prog_mode_out;
            busy_out <= (st_r != FPCH_IDLE) || !fifo_wr_rdy;
        end
    end
endmodule

// ---- rtl/fpch_pkg.sv ----
// Constants and types for the flash programming command handler
// Summary of operation
// - Commands travel on single-wire serial pin
// - Enter programming mode once communication begins
// - Unused pins hold their reset state
// - Self-programming pins match halt mode state
// - Logic runs on internal fast oscillator
// - Programmer sends commands, device sends responses
// - Only programmer originates commands
// - Every command answered with ack or nak
// - Verify compares flash region with data
// - Chip erase clears whole flash array
// - Block erase clears only named block
// - Blank check reports whether block erased
// - Write programs data into named region
// - Signature query returns identity and organisation
// - Version query returns hardware and firmware
// - Checksum computed over named region
// - Sync reset command is answered
// - Baud command changes serial bit rate
package fpch_pkg;
    localparam int FPCH_CLK_HZ = 40_000_000;
    localparam int FPCH_ADDR_W = 8;
    localparam int FPCH_BLK_W = 4;
    localparam int FPCH_BLK_SHIFT = 4;
    localparam logic [7:0] FPCH_ERASED = 8'hFF;
    // Command codes
    localparam logic [7:0] FPCH_CMD_SYNC = 8'h00;
    localparam logic [7:0] FPCH_CMD_VERIFY = 8'h13;
    localparam logic [7:0] FPCH_CMD_CHIP_ERASE = 8'h20;
    localparam logic [7:0] FPCH_CMD_BLOCK_ERASE = 8'h22;
    localparam logic [7:0] FPCH_CMD_BLANK = 8'h32;
    localparam logic [7:0] FPCH_CMD_WRITE = 8'h40;
    localparam logic [7:0] FPCH_CMD_SIGNATURE = 8'hC0;
    localparam logic [7:0] FPCH_CMD_VERSION = 8'hC5;
    localparam logic [7:0] FPCH_CMD_CHECKSUM = 8'hB0;
    localparam logic [7:0] FPCH_CMD_SECURITY = 8'hA0;
    localparam logic [7:0] FPCH_CMD_BAUD = 8'h9A;
    // Response codes
    localparam logic [7:0] FPCH_ACK = 8'h06;
    localparam logic [7:0] FPCH_NAK = 8'h15;
    // Identity values, arbitrary
    localparam logic [7:0] FPCH_SIG_ID = 8'h5A;
    localparam logic [7:0] FPCH_HW_VER = 8'h01;
    localparam logic [7:0] FPCH_FW_VER = 8'h02;
    // Bit-rate table in bits per second, selected by baud command
    localparam int FPCH_BAUD_0 = 115_200;
    localparam int FPCH_BAUD_1 = 250_000;
    localparam int FPCH_BAUD_2 = 500_000;
    localparam int FPCH_BAUD_3 = 1_000_000;
    localparam logic [15:0] FPCH_DIV_0 = 16'(FPCH_CLK_HZ / FPCH_BAUD_0);
    localparam logic [15:0] FPCH_DIV_1 = 16'(FPCH_CLK_HZ / FPCH_BAUD_1);
    localparam logic [15:0] FPCH_DIV_2 = 16'(FPCH_CLK_HZ / FPCH_BAUD_2);
    localparam logic [15:0] FPCH_DIV_3 = 16'(FPCH_CLK_HZ / FPCH_BAUD_3);
    localparam int FPCH_FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        FPCH_RX_IDLE,
        FPCH_RX_START,
        FPCH_RX_DATA,
        FPCH_RX_STOP
    } fpch_rx_t;

    typedef enum logic [3:0] {
        FPCH_IDLE,
        FPCH_GET_ARG,
        FPCH_GET_DATA,
        FPCH_RUN,
        FPCH_SEND_RESP,
        FPCH_SEND_EXTRA,
        FPCH_WAIT_TX
    } fpch_state_t;
endpackage

// ---- rtl/fpch_fifo.sv ----
// Small synchronous FIFO for received bytes
`timescale 1ns/1ps
module fpch_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire empty = (wp_r == rp_r);
    wire do_wr = wr_valid_in && !full;
    wire do_rd = rd_ready_in && !empty;
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out = mem_r[rp_r[AW-1:0]];
    always_ff @(posedge sys_clk_in) begin
        if (do_wr) begin
            mem_r[wp_r[AW-1:0]] <= wr_data_in;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_r + (AW+1)'(do_wr);
            rp_r <= rp_r + (AW+1)'(do_rd);
        end
    end
endmodule

// ---- verif/fpch_asserts.sv ----
// Checker on the pins of the programming command handler
`timescale 1ns/1ps
module fpch_asserts #(
    parameter int ADDR_W = fpch_pkg::FPCH_ADDR_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic prog_serial_pin_primary_in,
    input wire logic prog_serial_pin_primary_out,
    input wire logic prog_serial_pin_primary_oe_out,
    input wire logic prog_serial_pin_alternate_in,
    input wire logic prog_serial_pin_alternate_out,
    input wire logic prog_serial_pin_alternate_oe_out,
    input wire logic pin_sel_alternate_in,
    input wire logic self_prog_in,
    input wire logic prog_mode_out,
    input wire logic port_hold_reset_out,
    input wire logic port_hold_halt_out,
    input wire logic busy_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic oe_p = prog_serial_pin_primary_oe_out;
    wire logic oe_a = prog_serial_pin_alternate_oe_out;
    wire logic tx_p = prog_serial_pin_primary_out;

    a_one_driver: assert property (!(oe_p && oe_a))
        else $error("both serial pins driven");
    a_idle_high: assert property (!oe_p |-> tx_p)
        else $error("primary line not high while released");
    a_start_low: assert property ($rose(oe_p) |-> ##[0:1] (!tx_p) [*8])
        else $error("start bit too short");
    a_stop_high: assert property ($fell(oe_p) |-> $past(tx_p))
        else $error("line released without stop bit");
    a_no_initiate: assert property ((oe_p || oe_a) |-> prog_mode_out)
        else $error("device sends before any command");
    a_mode_sticky: assert property (prog_mode_out |=> prog_mode_out)
        else $error("programming mode dropped");
    a_hold_reset: assert property (prog_mode_out |-> ##[0:1] port_hold_reset_out)
        else $error("pins not held at reset state");
    a_halt_hold: assert property ((self_prog_in && !prog_mode_out) |=> port_hold_halt_out)
        else $error("pins not held at halt state");
    a_halt_off: assert property (prog_mode_out |=> !port_hold_halt_out)
        else $error("halt hold during programming mode");
    a_busy_send: assert property ($rose(oe_p || oe_a) |-> busy_out)
        else $error("response sent while idle");

    c_primary: cover property ($rose(oe_p));
    c_alternate: cover property ($rose(oe_a));
    c_halt: cover property ($rose(port_hold_halt_out));
endmodule

// ---- verif/fpch_prog_model.sv ----
// Programmer model: sends commands and reads responses on one line
`timescale 1ns/1ps
module fpch_prog_model (
    input wire logic sys_clk_in,
    input wire logic line_in,
    output logic line_out
);
    int div = int'(fpch_pkg::FPCH_DIV_0);
    bit tail = 1'b0;
    initial line_out = 1'b1;

    // Only this side starts a transfer; 8N1, LSB first
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        if (tail) repeat (div - div / 2) @(negedge sys_clk_in);
        for (int i = 0; i < 9; i++) begin
            @(negedge sys_clk_in);
            line_out = f[i];
            repeat (div - 1) @(negedge sys_clk_in);
        end
        // Return mid stop bit so an early answer is not missed
        @(negedge sys_clk_in);
        line_out = 1'b1;
        repeat (div / 2) @(negedge sys_clk_in);
        tail = 1'b1;
    endtask

    task automatic recv_byte(output logic [7:0] b);
        int n;
        b = 8'hxx;
        n = 0;
        tail = 1'b0;
        while (line_in !== 1'b0 && n < 20000) begin
            @(negedge sys_clk_in);
            n++;
        end
        if (n < 20000) begin
            repeat (div / 2) @(negedge sys_clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(negedge sys_clk_in);
                b[i] = line_in;
            end
            // Wait out the stop bit so the device has released the line
            repeat (div + div / 2 + 2) @(negedge sys_clk_in);
        end
    endtask
endmodule

// ---- verif/flash_programming_command_handler_bench.sv ----
// Self-checking bench for the flash programming command handler
`timescale 1ns/1ps
module flash_programming_command_handler_bench;
    import fpch_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic sel = 1'b0;
    logic self_prog = 1'b0;
    logic tx_p, oe_p, tx_a, oe_a, mode, hold_rst, hold_halt, busy, prog_line;
    wire logic wire_p = oe_p ? tx_p : (sel | prog_line);
    wire logic wire_a = oe_a ? tx_a : (!sel | prog_line);
    wire logic line_back = sel ? wire_a : wire_p;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 32'hefe8;
    int divs[4];
    logic [7:0] mem [256];
    logic [7:0] s, e, b;
    logic [3:0] blk;

    always #12.5 sys_clk_in = ~sys_clk_in;

    fpch_top uut (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .prog_serial_pin_primary_in(wire_p),
        .prog_serial_pin_primary_out(tx_p),
        .prog_serial_pin_primary_oe_out(oe_p),
        .prog_serial_pin_alternate_in(wire_a),
        .prog_serial_pin_alternate_out(tx_a),
        .prog_serial_pin_alternate_oe_out(oe_a),
        .pin_sel_alternate_in(sel),
        .self_prog_in(self_prog),
        .prog_mode_out(mode),
        .port_hold_reset_out(hold_rst),
        .port_hold_halt_out(hold_halt),
        .busy_out(busy)
    );

    fpch_prog_model prog (.sys_clk_in(sys_clk_in), .line_in(line_back), .line_out(prog_line));

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic expect_resp(input logic [7:0] exp);
        logic [7:0] r;
        prog.recv_byte(r);
        chk_byte(r, exp);
    endtask

    function automatic bit is_cmd(input logic [7:0] c);
        return c inside {FPCH_CMD_SYNC, FPCH_CMD_VERIFY, FPCH_CMD_CHIP_ERASE, FPCH_CMD_BLOCK_ERASE,
            FPCH_CMD_BLANK, FPCH_CMD_WRITE, FPCH_CMD_SIGNATURE, FPCH_CMD_VERSION,
            FPCH_CMD_CHECKSUM, FPCH_CMD_SECURITY, FPCH_CMD_BAUD};
    endfunction

    function automatic logic [7:0] sum_range(input logic [7:0] a0, input logic [7:0] a1);
        logic [7:0] acc;
        acc = mem[a0];
        while (a0 != a1) begin
            a0++;
            acc += mem[a0];
        end
        return acc;
    endfunction

    task automatic cmd3(input logic [7:0] c, input logic [7:0] a0, input logic [7:0] a1);
        prog.send_byte(c);
        prog.send_byte(a0);
        prog.send_byte(a1);
    endtask

    // Data mode: 0 write fresh random, 1 send stored, 2 send stored with one byte flipped
    task automatic data_range(input logic [7:0] a0, input logic [7:0] a1, input int mode_sel);
        logic [7:0] a;
        a = a0;
        do begin
            // Never the erased value, so a written block cannot look blank
            if (mode_sel == 0) mem[a] = 8'($random(seed)) & 8'hFE;
            prog.send_byte((mode_sel == 2 && a == a1) ? ~mem[a] : mem[a]);
            a++;
        end while (a != 8'(a1 + 8'h01));
    endtask

    task automatic blank(input logic [3:0] k, input logic [7:0] exp);
        prog.send_byte(FPCH_CMD_BLANK);
        prog.send_byte({4'h0, k});
        expect_resp(exp);
    endtask

    task automatic cks(input logic [7:0] a0, input logic [7:0] a1);
        cmd3(FPCH_CMD_CHECKSUM, a0, a1);
        expect_resp(FPCH_ACK);
        expect_resp(sum_range(a0, a1));
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk_in);
        mismatches++;
        close_out;
    end

    initial begin
        divs = '{int'(FPCH_DIV_0), int'(FPCH_DIV_1), int'(FPCH_DIV_2), int'(FPCH_DIV_3)};
        repeat (20) @(negedge sys_clk_in);
        chk_bit(tx_p, 1'b1);
        chk_bit(oe_p, 1'b0);
        chk_bit(busy, 1'b0);
        rst_b_in = 1'b1;
        self_prog = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        chk_bit(hold_halt, 1'b1);
        chk_bit(mode, 1'b0);
        self_prog = 1'b0;
        prog.send_byte(FPCH_CMD_SYNC);
        expect_resp(FPCH_ACK);
        chk_bit(mode, 1'b1);
        chk_bit(hold_rst, 1'b1);
        self_prog = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        chk_bit(hold_halt, 1'b0);
        self_prog = 1'b0;
        // Every rate; the answer already runs at the new one
        for (int k = 0; k < 4; k++) begin
            prog.send_byte(FPCH_CMD_BAUD);
            prog.send_byte(8'(k));
            prog.div = divs[k];
            expect_resp(FPCH_ACK);
        end
        for (int k = 0; k < 4; k++) begin
            do b = 8'($random(seed)); while (is_cmd(b));
            prog.send_byte(b);
            expect_resp(FPCH_NAK);
        end
        prog.send_byte(FPCH_CMD_CHIP_ERASE);
        expect_resp(FPCH_ACK);
        foreach (mem[i]) mem[i] = FPCH_ERASED;
        blk = 4'($random(seed));
        blank(blk + 4'h1, FPCH_ACK);
        s = {blk, 4'($random(seed))};
        e = {blk, 4'hF};
        cmd3(FPCH_CMD_WRITE, s, e);
        data_range(s, e, 0);
        expect_resp(FPCH_ACK);
        cmd3(FPCH_CMD_WRITE, {blk + 4'h1, 4'h0}, {blk + 4'h1, 4'h3});
        data_range({blk + 4'h1, 4'h0}, {blk + 4'h1, 4'h3}, 0);
        expect_resp(FPCH_ACK);
        cmd3(FPCH_CMD_VERIFY, s, e);
        data_range(s, e, 1);
        expect_resp(FPCH_ACK);
        cmd3(FPCH_CMD_VERIFY, s, e);
        data_range(s, e, 2);
        expect_resp(FPCH_NAK);
        cks(s, {blk + 4'h1, 4'h3});
        blank(blk, FPCH_NAK);
        prog.send_byte(FPCH_CMD_BLOCK_ERASE);
        prog.send_byte({4'h0, blk});
        expect_resp(FPCH_ACK);
        for (int i = 0; i < 16; i++) mem[{blk, 4'(i)}] = FPCH_ERASED;
        blank(blk, FPCH_ACK);
        blank(blk + 4'h1, FPCH_NAK);
        prog.send_byte(FPCH_CMD_SIGNATURE);
        expect_resp(FPCH_ACK);
        expect_resp(FPCH_SIG_ID);
        expect_resp(8'(FPCH_ADDR_W));
        prog.send_byte(FPCH_CMD_VERSION);
        expect_resp(FPCH_ACK);
        expect_resp(FPCH_HW_VER);
        expect_resp(FPCH_FW_VER);
        prog.send_byte(FPCH_CMD_SECURITY);
        prog.send_byte(8'h01);
        expect_resp(FPCH_ACK);
        prog.send_byte(FPCH_CMD_CHIP_ERASE);
        expect_resp(FPCH_NAK);
        cks({blk + 4'h1, 4'h0}, {blk + 4'h1, 4'h3});
        sel = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        prog.send_byte(FPCH_CMD_SYNC);
        expect_resp(FPCH_ACK);
        close_out;
    end
endmodule

bind fpch_top fpch_asserts #(.ADDR_W(ADDR_W)) chk (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .prog_serial_pin_primary_in(prog_serial_pin_primary_in),
    .prog_serial_pin_primary_out(prog_serial_pin_primary_out),
    .prog_serial_pin_primary_oe_out(prog_serial_pin_primary_oe_out),
    .prog_serial_pin_alternate_in(prog_serial_pin_alternate_in),
    .prog_serial_pin_alternate_out(prog_serial_pin_alternate_out),
    .prog_serial_pin_alternate_oe_out(prog_serial_pin_alternate_oe_out),
    .pin_sel_alternate_in(pin_sel_alternate_in),
    .self_prog_in(self_prog_in),
    .prog_mode_out(prog_mode_out),
    .port_hold_reset_out(port_hold_reset_out),
    .port_hold_halt_out(port_hold_halt_out),
    .busy_out(busy_out)
);
